/* logic/dtc_pkg.sv */
// Package: register map, field layout, resets, codes and carriers
package dtc_pkg;
   localparam int unsigned CHANNELS = 2;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned OFS_W = 8;
   localparam int unsigned FGAIN_W = 6;
   localparam int unsigned CGAIN_W = 2;
   // Trim resolutions: offset in eighths of a step, gain in halves
   localparam int unsigned OFS_FRAC_BITS = 3;
   localparam int unsigned FGAIN_FRAC_BITS = 1;
   // Register byte addresses
   localparam logic [7:0] ADDR_DATA0 = 8'h00;
   localparam logic [7:0] ADDR_DATA1 = 8'h04;
   localparam logic [7:0] ADDR_CGAIN0 = 8'h08;
   localparam logic [7:0] ADDR_CGAIN1 = 8'h0C;
   localparam logic [7:0] ADDR_FGAIN0 = 8'h10;
   localparam logic [7:0] ADDR_FGAIN1 = 8'h14;
   localparam logic [7:0] ADDR_OFS0 = 8'h18;
   localparam logic [7:0] ADDR_OFS1 = 8'h1C;
   localparam logic [7:0] ADDR_FUNC = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_CODE0 = 8'h28;
   localparam logic [7:0] ADDR_CODE1 = 8'h2C;
   // Function register fields
   localparam int unsigned FUNC_LGND_BIT = 0;
   localparam int unsigned FUNC_DIR_BIT = 1;
   localparam int unsigned FUNC_VAL0_BIT = 2;
   localparam int unsigned FUNC_VAL1_BIT = 3;
   // Status register fields
   localparam int unsigned STAT_SUPPLY_BIT = 0;
   localparam int unsigned STAT_CLAMP0_BIT = 1;
   localparam int unsigned STAT_CLAMP1_BIT = 2;
   localparam int unsigned STAT_PIN0_BIT = 3;
   localparam int unsigned STAT_PIN1_BIT = 4;
   // Reset values
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [OFS_W-1:0] OFS_RST = 8'h00;
   localparam logic [FGAIN_W-1:0] FGAIN_RST = 6'h00;
   localparam logic [CGAIN_W-1:0] CGAIN_RST = 2'h0;
   // Coarse range codes
   localparam logic [CGAIN_W-1:0] RANGE_10V = 2'h0;
   localparam logic [CGAIN_W-1:0] RANGE_10V25 = 2'h1;
   localparam logic [CGAIN_W-1:0] RANGE_10V5 = 2'h2;
   // Range scale in 1/256: 256, 262.4 and 268.8 rounded up
   localparam logic [9:0] SCALE_10V = 10'h100;
   localparam logic [9:0] SCALE_10V25 = 10'h107;
   localparam logic [9:0] SCALE_10V5 = 10'h10D;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [OFS_W-1:0] ofs;
      logic [FGAIN_W-1:0] fgain;
      logic [CGAIN_W-1:0] cgain;
      logic lgnd_en;
   } dtc_chan_cfg_t;

   typedef struct packed {
      logic amp_connect_gate;
      logic ground_clamp_gate;
   } dtc_gates_t;
endpackage : dtc_pkg

/* logic/dtc_chan.sv */
// One channel: trimmed output code and power-up clamp sequencing
`timescale 1ns/1ps
module dtc_chan
   import dtc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire dtc_chan_cfg_t cfg_in,
   input wire logic data_wr_in,
   input wire logic supply_ok_in,
   input wire logic clamp_force_in_n,
   input wire logic signed [7:0] gnd_diff_in,
   output dtc_gates_t gates_out,
   output logic [DATA_W-1:0] code_out
);
   typedef enum logic [1:0] {
      ST_CLAMP = 2'b01,
      ST_RUN = 2'b10
   } dtc_clamp_st_t;

   dtc_clamp_st_t st_ff, nxt_st;
   logic [DATA_W-1:0] code_ff, nxt_code;
   logic signed [31:0] acc;
   logic signed [31:0] gain_term;
   logic [9:0] scale;

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         ST_CLAMP: begin
            if (supply_ok_in && clamp_force_in_n && data_wr_in) begin
               nxt_st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!supply_ok_in || !clamp_force_in_n) begin
               nxt_st = ST_CLAMP;
            end
         end
         default: nxt_st = ST_CLAMP;
      endcase
   end

   always_comb begin
      unique case (cfg_in.cgain)
         RANGE_10V25: scale = SCALE_10V25;
         RANGE_10V5: scale = SCALE_10V5;
         default: scale = SCALE_10V;
      endcase
      // twos complement code, zero at 0x0000
      acc = $signed({{16{cfg_in.data[DATA_W-1]}}, cfg_in.data}) * 256;
      acc = acc / $signed({22'h0, scale});
      // fine gain, half step at each end
      gain_term = ($signed({{16{cfg_in.data[DATA_W-1]}}, cfg_in.data})
         * $signed({{26{cfg_in.fgain[FGAIN_W-1]}}, cfg_in.fgain})) >>> 16;
      acc = acc - gain_term;
      acc = acc + ($signed({{24{cfg_in.ofs[OFS_W-1]}}, cfg_in.ofs})
         >>> OFS_FRAC_BITS);
      // local ground correction
      // A raised channel ground lifts the output by the same amount
      if (cfg_in.lgnd_en) begin
         acc = acc + $signed({{24{gnd_diff_in[7]}}, gnd_diff_in});
      end
      if (acc > 32'sd32767) begin
         acc = 32'sd32767;
      end
      if (acc < -32'sd32768) begin
         acc = -32'sd32768;
      end
      nxt_code = (nxt_st == ST_RUN) ? acc[DATA_W-1:0] : DATA_RST;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= ST_CLAMP;
         code_ff <= DATA_RST;
      end else begin
         st_ff <= nxt_st;
         code_ff <= nxt_code;
      end
   end

   assign gates_out.amp_connect_gate = (st_ff == ST_RUN);
   assign gates_out.ground_clamp_gate = (st_ff != ST_RUN);
   assign code_out = code_ff;
endmodule : dtc_chan

/* logic/dtc_top.sv */
// Trim, range and clamp control with AXI4-Lite registers and I/O port
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic supply_ok_in,
   input wire logic clamp_force_in_n,
   input wire logic signed [7:0] gnd_diff0_in,
   input wire logic signed [7:0] gnd_diff1_in,
   output logic supply_good_out_n,
   output logic [1:0] amp_connect_gate_out,
   output logic [1:0] ground_clamp_gate_out,
   output logic [DATA_W-1:0] code0_out,
   output logic [DATA_W-1:0] code1_out,
   input wire logic port_bit_zero_in,
   output logic port_bit_zero_out,
   output logic port_bit_zero_oe_out,
   input wire logic port_bit_one_in,
   output logic port_bit_one_out,
   output logic port_bit_one_oe_out
);
   logic [DATA_W-1:0] data_ff [CHANNELS], nxt_data [CHANNELS];
   logic [OFS_W-1:0] ofs_ff [CHANNELS], nxt_ofs [CHANNELS];
   logic [FGAIN_W-1:0] fgain_ff [CHANNELS], nxt_fgain [CHANNELS];
   logic [CGAIN_W-1:0] cgain_ff [CHANNELS], nxt_cgain [CHANNELS];
   logic [CHANNELS-1:0] data_wr_ff, nxt_data_wr;
   logic lgnd_ff, nxt_lgnd;
   logic dir_ff, nxt_dir;
   logic [1:0] pval_ff, nxt_pval;
   logic [1:0] pin_ff, nxt_pin;

   // AXI write and read channel state
   logic aw_full_ff, nxt_aw_full;
   logic w_full_ff, nxt_w_full;
   logic [7:0] aw_addr_ff, nxt_aw_addr;
   logic [31:0] w_data_ff, nxt_w_data;
   logic [3:0] w_strb_ff, nxt_w_strb;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;

   logic do_wr;
   logic [DATA_W-1:0] code [CHANNELS];
   dtc_gates_t gates [CHANNELS];
   dtc_chan_cfg_t cfg [CHANNELS];
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] status;

   assign s_axi_awready_out = !aw_full_ff && !bvalid_ff;
   assign s_axi_wready_out = !w_full_ff && !bvalid_ff;
   assign s_axi_arready_out = !rvalid_ff;
   assign do_wr = aw_full_ff && w_full_ff && !bvalid_ff;
   assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
      {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   assign wval = w_data_ff & wmask;

   always_comb begin
      status = 32'h0000_0000;
      status[STAT_SUPPLY_BIT] = supply_ok_in;
      status[STAT_CLAMP0_BIT] = gates[0].ground_clamp_gate;
      status[STAT_CLAMP1_BIT] = gates[1].ground_clamp_gate;
      status[STAT_PIN0_BIT] = pin_ff[0];
      status[STAT_PIN1_BIT] = pin_ff[1];
   end

   always_comb begin
      nxt_aw_full = aw_full_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_full = w_full_ff;
      nxt_w_data = w_data_ff;
      nxt_w_strb = w_strb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_data = data_ff;
      nxt_ofs = ofs_ff;
      nxt_fgain = fgain_ff;
      nxt_cgain = cgain_ff;
      nxt_lgnd = lgnd_ff;
      nxt_dir = dir_ff;
      nxt_pval = pval_ff;
      nxt_data_wr = '0;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
         nxt_aw_full = 1'b1;
         nxt_aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         nxt_w_full = 1'b1;
         nxt_w_data = s_axi_wdata_in;
         nxt_w_strb = s_axi_wstrb_in;
      end
      if (do_wr) begin
         nxt_aw_full = 1'b0;
         nxt_w_full = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OKAY;
         unique case (aw_addr_ff)
            ADDR_DATA0: begin
               nxt_data[0] = (data_ff[0] & ~wmask[15:0]) | wval[15:0];
               nxt_data_wr[0] = 1'b1;
            end
            ADDR_DATA1: begin
               nxt_data[1] = (data_ff[1] & ~wmask[15:0]) | wval[15:0];
               nxt_data_wr[1] = 1'b1;
            end
            ADDR_CGAIN0: begin
               if (w_strb_ff[0]) nxt_cgain[0] = w_data_ff[CGAIN_W-1:0];
            end
            ADDR_CGAIN1: begin
               if (w_strb_ff[0]) nxt_cgain[1] = w_data_ff[CGAIN_W-1:0];
            end
            ADDR_FGAIN0: begin
               if (w_strb_ff[0]) nxt_fgain[0] = w_data_ff[FGAIN_W-1:0];
            end
            ADDR_FGAIN1: begin
               if (w_strb_ff[0]) nxt_fgain[1] = w_data_ff[FGAIN_W-1:0];
            end
            ADDR_OFS0: begin
               if (w_strb_ff[0]) nxt_ofs[0] = w_data_ff[OFS_W-1:0];
            end
            ADDR_OFS1: begin
               if (w_strb_ff[0]) nxt_ofs[1] = w_data_ff[OFS_W-1:0];
            end
            ADDR_FUNC: begin
               if (w_strb_ff[0]) begin
                  nxt_lgnd = w_data_ff[FUNC_LGND_BIT];
                  nxt_dir = w_data_ff[FUNC_DIR_BIT];
                  nxt_pval = {w_data_ff[FUNC_VAL1_BIT],
                     w_data_ff[FUNC_VAL0_BIT]};
               end
            end
            ADDR_STATUS, ADDR_CODE0, ADDR_CODE1: nxt_bresp = RESP_OKAY;
            default: nxt_bresp = RESP_SLVERR;
         endcase
      end
      if (bvalid_ff && s_axi_bready_in) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         nxt_rdata = 32'h0000_0000;
         unique case (s_axi_araddr_in)
            ADDR_DATA0: nxt_rdata[DATA_W-1:0] = data_ff[0];
            ADDR_DATA1: nxt_rdata[DATA_W-1:0] = data_ff[1];
            ADDR_CGAIN0: nxt_rdata[CGAIN_W-1:0] = cgain_ff[0];
            ADDR_CGAIN1: nxt_rdata[CGAIN_W-1:0] = cgain_ff[1];
            ADDR_FGAIN0: nxt_rdata[FGAIN_W-1:0] = fgain_ff[0];
            ADDR_FGAIN1: nxt_rdata[FGAIN_W-1:0] = fgain_ff[1];
            ADDR_OFS0: nxt_rdata[OFS_W-1:0] = ofs_ff[0];
            ADDR_OFS1: nxt_rdata[OFS_W-1:0] = ofs_ff[1];
            ADDR_FUNC: begin
               nxt_rdata[FUNC_LGND_BIT] = lgnd_ff;
               nxt_rdata[FUNC_DIR_BIT] = dir_ff;
               // readback of pin levels when inputs
               nxt_rdata[FUNC_VAL0_BIT] = dir_ff ? pval_ff[0] : pin_ff[0];
               nxt_rdata[FUNC_VAL1_BIT] = dir_ff ? pval_ff[1] : pin_ff[1];
            end
            ADDR_STATUS: nxt_rdata = status;
            ADDR_CODE0: nxt_rdata[DATA_W-1:0] = code[0];
            ADDR_CODE1: nxt_rdata[DATA_W-1:0] = code[1];
            default: nxt_rresp = RESP_SLVERR;
         endcase
      end else if (rvalid_ff && s_axi_rready_in) begin
         nxt_rvalid = 1'b0;
      end
   end

   assign nxt_pin = {port_bit_one_in, port_bit_zero_in};

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < CHANNELS; i++) begin
            data_ff[i] <= DATA_RST;
            ofs_ff[i] <= OFS_RST;
            fgain_ff[i] <= FGAIN_RST;
            cgain_ff[i] <= CGAIN_RST;
         end
         data_wr_ff <= '0;
         lgnd_ff <= 1'b0;
         dir_ff <= 1'b0;
         pval_ff <= 2'h0;
         pin_ff <= 2'h0;
         aw_full_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_full_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end else begin
         data_ff <= nxt_data;
         ofs_ff <= nxt_ofs;
         fgain_ff <= nxt_fgain;
         cgain_ff <= nxt_cgain;
         data_wr_ff <= nxt_data_wr;
         lgnd_ff <= nxt_lgnd;
         dir_ff <= nxt_dir;
         pval_ff <= nxt_pval;
         pin_ff <= nxt_pin;
         aw_full_ff <= nxt_aw_full;
         aw_addr_ff <= nxt_aw_addr;
         w_full_ff <= nxt_w_full;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         cfg[i].data = data_ff[i];
         cfg[i].ofs = ofs_ff[i];
         cfg[i].fgain = fgain_ff[i];
         cfg[i].cgain = cgain_ff[i];
         cfg[i].lgnd_en = lgnd_ff;
      end
   end

   dtc_chan u_chan0 (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .cfg_in(cfg[0]),
      .data_wr_in(data_wr_ff[0]),
      .supply_ok_in(supply_ok_in),
      .clamp_force_in_n(clamp_force_in_n),
      .gnd_diff_in(gnd_diff0_in),
      .gates_out(gates[0]),
      .code_out(code[0])
   );

   dtc_chan u_chan1 (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .cfg_in(cfg[1]),
      .data_wr_in(data_wr_ff[1]),
      .supply_ok_in(supply_ok_in),
      .clamp_force_in_n(clamp_force_in_n),
      .gnd_diff_in(gnd_diff1_in),
      .gates_out(gates[1]),
      .code_out(code[1])
   );

   assign s_axi_bvalid_out = bvalid_ff;
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign supply_good_out_n = !supply_ok_in;
   assign amp_connect_gate_out = {gates[1].amp_connect_gate,
      gates[0].amp_connect_gate};
   assign ground_clamp_gate_out = {gates[1].ground_clamp_gate,
      gates[0].ground_clamp_gate};
   assign code0_out = code[0];
   assign code1_out = code[1];
   assign port_bit_zero_out = pval_ff[0];
   assign port_bit_one_out = pval_ff[1];
   assign port_bit_zero_oe_out = dir_ff;
   assign port_bit_one_oe_out = dir_ff;
endmodule : dtc_top

/* verification/dtc_pin_env.sv */
// Board-side model of the two port pins and their outside drivers
`timescale 1ns/1ps
module dtc_pin_env (
   input wire logic [1:0] drv_in,
   input wire logic [1:0] oe_in,
   input wire logic [1:0] ext_in,
   output logic [1:0] pin_out
);
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_out[i] = oe_in[i] ? drv_in[i] : ext_in[i];
      end
   end
endmodule : dtc_pin_env

/* verification/dtc_top_asserts.sv */
// Checker for clamp sequencing, supply flag, port direction and codes
`timescale 1ns/1ps
module dtc_top_asserts
   import dtc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic supply_ok_in,
   input wire logic clamp_force_in_n,
   input wire logic supply_good_out_n,
   input wire logic [1:0] amp_connect_gate_out,
   input wire logic [1:0] ground_clamp_gate_out,
   input wire logic [DATA_W-1:0] code0_out,
   input wire logic [DATA_W-1:0] code1_out,
   input wire logic port_bit_zero_oe_out,
   input wire logic port_bit_one_oe_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   property p_sgood;
      supply_good_out_n == !supply_ok_in;
   endproperty
   a_sgood: assert property (p_sgood)
      else $error("supply flag differs from detector");
   property p_gates;
      amp_connect_gate_out == ~ground_clamp_gate_out;
   endproperty
   a_gates: assert property (p_gates)
      else $error("amp gate and clamp gate both on or both off");
   property p_brown;
      !supply_ok_in |=> ground_clamp_gate_out == 2'h3;
   endproperty
   a_brown: assert property (p_brown)
      else $error("clamp not engaged after supply loss");
   property p_force;
      !clamp_force_in_n |=> amp_connect_gate_out == 2'h0;
   endproperty
   a_force: assert property (p_force)
      else $error("amp still connected under forced clamp");
   property p_release;
      $rose(amp_connect_gate_out[0]) |->
         $past(supply_ok_in) && $past(clamp_force_in_n);
   endproperty
   a_release: assert property (p_release)
      else $error("clamp released without good conditions");
   property p_dir;
      port_bit_zero_oe_out == port_bit_one_oe_out;
   endproperty
   a_dir: assert property (p_dir)
      else $error("port pins differ in direction");
   property p_code0;
      ground_clamp_gate_out[0] && $past(ground_clamp_gate_out[0]) |->
         code0_out == 16'h0000;
   endproperty
   a_code0: assert property (p_code0)
      else $error("channel zero code not zero while clamped");
   property p_code1;
      ground_clamp_gate_out[1] [*2] |-> code1_out == 16'h0000;
   endproperty
   a_code1: assert property (p_code1)
      else $error("channel one code not zero while clamped");
endmodule : dtc_top_asserts

bind dtc_top dtc_top_asserts u_asserts (
   .mclk_in,
   .rst_n_in,
   .supply_ok_in,
   .clamp_force_in_n,
   .supply_good_out_n,
   .amp_connect_gate_out,
   .ground_clamp_gate_out,
   .code0_out,
   .code1_out,
   .port_bit_zero_oe_out,
   .port_bit_one_oe_out
);

/* verification/dtc_top_bench.sv */
// Self-checking bench: register, clamp, trim and port tests
`timescale 1ns/1ps
`define CHECK(nm, got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("MISMATCH %s exp %h got %h", nm, exp, got); \
   end \
end
module dtc_top_bench
   import dtc_pkg::*;
();
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic supply_ok = 1'b0, force_n = 1'b1;
   logic signed [7:0] gnd0 = 8'sh00;
   logic [1:0] ext = 2'h0;
   wire awready, wready, bvalid, arready, rvalid, sgood_n;
   wire [1:0] bresp, rresp, amp, clamp, pout, poe, pin;
   wire [31:0] rdata;
   wire [15:0] code0, code1;
   logic [31:0] rd_d;
   logic [1:0] rd_r;
   logic [1:0] rng [3] = '{RANGE_10V, RANGE_10V25, RANGE_10V5};
   int errors = 0;
   int cmp_count = 0;

   always #2 mclk_in = ~mclk_in;

   dtc_top dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .supply_ok_in(supply_ok),
      .clamp_force_in_n(force_n), .gnd_diff0_in(gnd0),
      .gnd_diff1_in(8'sh00), .supply_good_out_n(sgood_n),
      .amp_connect_gate_out(amp), .ground_clamp_gate_out(clamp),
      .code0_out(code0), .code1_out(code1),
      .port_bit_zero_in(pin[0]), .port_bit_zero_out(pout[0]),
      .port_bit_zero_oe_out(poe[0]), .port_bit_one_in(pin[1]),
      .port_bit_one_out(pout[1]), .port_bit_one_oe_out(poe[1])
   );

   dtc_pin_env u_env (
      .drv_in(pout),
      .oe_in(poe),
      .ext_in(ext),
      .pin_out(pin)
   );

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er = RESP_OKAY);
      bit aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (aw_p && awready === 1'b1) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end while (aw_p || w_p);
      // Response ready stays high between transfers
      do @(posedge mclk_in); while (bvalid !== 1'b1);
      `CHECK("bresp", bresp, er)
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
         output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
      rd(a, rd_d, rd_r);
      `CHECK("rresp", rd_r, RESP_OKAY)
      `CHECK("rdata", rd_d & m, e)
   endtask : rc

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   initial begin
      tick(20);
      rst_n_in <= 1'b1;
      tick(1);
      rc(ADDR_OFS0, 32'hFF, {24'h0, OFS_RST});
      rc(ADDR_FGAIN1, 32'h3F, {26'h0, FGAIN_RST});
      rc(ADDR_CGAIN0, 32'h3, {30'h0, CGAIN_RST});
      rc(ADDR_FUNC, 32'h2, 32'h0);
      `CHECK("oe", poe, 2'h0)
      rc(ADDR_STATUS, 32'h6, 32'h6);
      `CHECK("sgood_n", sgood_n, 1'b1)
      wr(ADDR_DATA0, 32'h0);
      tick(4);
      `CHECK("amp", amp, 2'h0)
      supply_ok <= 1'b1;
      tick(4);
      `CHECK("amp", amp, 2'h0)
      `CHECK("sgood_n", sgood_n, 1'b0)
      wr(ADDR_OFS0, 32'hF0);
      rc(ADDR_OFS0, 32'hFF, 32'hF0);
      rc(ADDR_OFS1, 32'hFF, 32'h0);
      wr(ADDR_FGAIN0, 32'h08);
      rc(ADDR_FGAIN0, 32'h3F, 32'h08);
      wr(ADDR_FGAIN0, 32'h0);
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_CGAIN0, {30'h0, rng[i]});
         rc(ADDR_CGAIN0, 32'h3, {30'h0, rng[i]});
      end
      wr(ADDR_CGAIN0, {30'h0, RANGE_10V});
      wr(ADDR_DATA0, 32'h0);
      tick(3);
      `CHECK("amp", amp, 2'h1)
      `CHECK("clamp", clamp, 2'h2)
      `CHECK("code1", code1, 16'h0000)
      `CHECK("code0", code0, 16'hFFFE)
      wr(ADDR_OFS0, 32'h08);
      tick(3);
      `CHECK("code0", code0, 16'h0001)
      wr(ADDR_OFS0, 32'h0);
      tick(3);
      `CHECK("code0", code0, 16'h0000)
      wr(ADDR_DATA0, 32'h8000);
      tick(3);
      `CHECK("code0", code0, 16'h8000)
      rc(ADDR_CODE0, 32'hFFFF, 32'h8000);
      wr(ADDR_FGAIN0, 32'h08);
      tick(3);
      `CHECK("code0", code0, 16'h8004)
      wr(ADDR_FGAIN0, 32'h0);
      wr(ADDR_DATA0, 32'h0);
      gnd0 <= 8'sh03;
      wr(ADDR_FUNC, 32'h1 << FUNC_LGND_BIT);
      tick(3);
      `CHECK("code0", code0, 16'h0003)
      wr(ADDR_FUNC, 32'h0);
      tick(3);
      `CHECK("code0", code0, 16'h0000)
      supply_ok <= 1'b0;
      tick(3);
      `CHECK("amp", amp, 2'h0)
      supply_ok <= 1'b1;
      tick(4);
      `CHECK("amp", amp, 2'h0)
      wr(ADDR_DATA0, 32'h0);
      tick(3);
      `CHECK("amp", amp, 2'h1)
      force_n <= 1'b0;
      tick(3);
      `CHECK("amp", amp, 2'h0)
      `CHECK("sgood_n", sgood_n, 1'b0)
      force_n <= 1'b1;
      wr(ADDR_DATA0, 32'h0);
      tick(3);
      `CHECK("amp", amp, 2'h1)
      ext <= 2'h1;
      tick(3);
      rc(ADDR_STATUS, 32'h18, 32'h1 << STAT_PIN0_BIT);
      rc(ADDR_FUNC, 32'hC, 32'h1 << FUNC_VAL0_BIT);
      wr(ADDR_FUNC, (32'h1 << FUNC_DIR_BIT) | (32'h1 << FUNC_VAL1_BIT));
      tick(3);
      `CHECK("oe", poe, 2'h3)
      `CHECK("pout", pout, 2'h2)
      rc(ADDR_STATUS, 32'h18, 32'h1 << STAT_PIN1_BIT);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd(8'h40, rd_d, rd_r);
      `CHECK("rresp", rd_r, RESP_SLVERR)
      results();
   end

   initial begin
      tick(20000);
      errors++;
      $display("watchdog expired before the tests ended");
      results();
   end
endmodule : dtc_top_bench
